// File: logic/rftx_pkg.sv
// rftx_pkg: register map, field positions and reset values of the
// transmitter power and synthesizer test register bank.
// assumes: APB slave with 32-bit data, one register per aligned word.
package rftx_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] RFTX_IDX_POWER = 10'h01C;
    localparam logic [9:0] RFTX_IDX_SLEEP = 10'h020;
    localparam logic [9:0] RFTX_IDX_DACPUMP = 10'h021;
    localparam logic [9:0] RFTX_IDX_LOOP = 10'h022;
    localparam logic [9:0] RFTX_IDX_OSCCAL = 10'h023;
    localparam logic [9:0] RFTX_IDX_PUMPTEST = 10'h024;
    localparam logic [9:0] RFTX_IDX_COMPDITH = 10'h025;
    localparam logic [9:0] RFTX_IDX_STATUS = 10'h026;

    // tx_power_level fields
    localparam int RFTX_POS_HIGH = 4;
    localparam int RFTX_POS_LOW = 0;
    localparam logic [3:0] RFTX_RST_HIGH = 4'h0;
    localparam logic [3:0] RFTX_RST_LOW = 4'hF;

    // block_power_down fields (bits 3:0 reserved)
    localparam int RFTX_POS_AMP_SLEEP = 7;
    localparam int RFTX_POS_OSC_SLEEP = 6;
    localparam int RFTX_POS_DIV_SLEEP = 5;
    localparam int RFTX_POS_PUMP_SLEEP = 4;
    localparam logic [3:0] RFTX_RST_SLEEP = 4'h0;
    localparam logic [1:0] RFTX_SLEEP_MODE_GATED = 2'h2;

    // dac_and_pump_override fields
    localparam int RFTX_POS_DAC_OPEN = 4;
    localparam int RFTX_POS_PUMP_CO = 0;
    localparam logic [3:0] RFTX_RST_DAC_OPEN = 4'h4;
    localparam logic [3:0] RFTX_RST_PUMP_CO = 4'hD;

    // loop_override_control fields
    localparam int RFTX_POS_BREAK = 7;
    localparam int RFTX_POS_PUMP_OVR = 6;
    localparam int RFTX_POS_ARRAY_OVR = 5;
    localparam int RFTX_POS_ARRAY_AO = 0;
    localparam logic [4:0] RFTX_RST_ARRAY_AO = 5'h10;

    // vco_current_cal_test fields
    localparam int RFTX_POS_MANUAL = 7;
    localparam int RFTX_POS_CUR_OVR = 6;
    localparam int RFTX_POS_CUR_CO = 0;
    localparam logic [5:0] RFTX_RST_CUR_CO = 6'h06;

    // charge_pump_test fields (bits 4:0 reserved)
    localparam int RFTX_POS_PUMP_DIS = 7;
    localparam int RFTX_POS_PUMP_UP = 6;
    localparam int RFTX_POS_PUMP_DN = 5;

    // comparator_dither_test fields (bits 5:0 reserved)
    localparam int RFTX_POS_FCOMP_EN = 7;
    localparam int RFTX_POS_DITHER = 6;
    localparam logic RFTX_RST_DITHER = 1'b1;

    // status register fields
    localparam int RFTX_POS_ST_COMP = 6;
    localparam int RFTX_POS_ST_CUR = 0;

endpackage

// File: logic/rftx_regs.sv
// rftx_regs: APB register bank for amplifier power levels, gated block
// sleep bits and synthesizer test overrides, with manual VCO calibration.
// assumes: analog blocks take the registered control outputs; calibrated
// values and the comparator arrive synchronous to pclk.
//
// Added by the designer: the APB interface to the registers.
module rftx_regs
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mode and calibrated values from the synthesizer
    input wire logic [1:0] sleep_mode_select,
    input wire logic [3:0] cal_dac_value,
    input wire logic [3:0] cal_pump_current,
    input wire logic [4:0] cal_osc_array,
    input wire logic [5:0] cal_osc_current,
    input wire logic osc_cal_comp,
    // amplifier controls
    output logic [3:0] high_array_level,
    output logic [3:0] low_array_level,
    // block sleep controls
    output logic amp_sleep,
    output logic osc_sleep,
    output logic divider_buffer_sleep,
    output logic pump_sleep,
    // synthesizer test controls
    output logic loop_open,
    output logic [3:0] dac_drive,
    output logic [3:0] pump_current,
    output logic [4:0] osc_array,
    output logic [5:0] osc_current,
    output logic osc_cal_clk,
    output logic pump_disable,
    output logic pump_force_up,
    output logic pump_force_down,
    output logic fcomp_out_en,
    output logic modulator_dither_en
);
    import rftx_pkg::*;

    typedef struct packed {
        logic [7:0] power;
        logic [3:0] sleep_bits;
        logic [7:0] dac_pump;
        logic [7:0] loop_ctl;
        logic [7:0] osc_cal;
        logic [2:0] pump_test;
        logic [1:0] comp_dith;
        logic cal_clk_prev;
        logic comp_sample;
        logic [3:0] sleep_out;
        logic loop_open;
        logic [3:0] dac_drive;
        logic [3:0] pump_current;
        logic [4:0] osc_array;
        logic [5:0] osc_current;
        logic osc_cal_clk;
        logic [31:0] rdata;
    } rftx_state_t;

    rftx_state_t state;
    rftx_state_t next_state;

    logic [9:0] index;
    logic aligned;
    logic mapped;
    logic setup;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic sleep_gate;
    logic cal_fall;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign index = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite && mapped && aligned && pstrb[0];
    assign wbyte = pwdata[7:0];
    assign pslverr = psel && penable && !(mapped && aligned);
    assign prdata = state.rdata;

    always_comb
    begin
        unique case (index)
            RFTX_IDX_POWER, RFTX_IDX_SLEEP, RFTX_IDX_DACPUMP, RFTX_IDX_LOOP,
            RFTX_IDX_OSCCAL, RFTX_IDX_PUMPTEST, RFTX_IDX_COMPDITH,
            RFTX_IDX_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // reserved bits read back as zero
    always_comb
    begin
        rbyte = 8'h00;
        unique case (index)
            RFTX_IDX_POWER:
                rbyte = state.power;
            RFTX_IDX_SLEEP:
                rbyte = {state.sleep_bits, 4'h0};
            RFTX_IDX_DACPUMP:
                rbyte = state.dac_pump;
            RFTX_IDX_LOOP:
                rbyte = state.loop_ctl;
            RFTX_IDX_OSCCAL:
                rbyte = state.osc_cal;
            RFTX_IDX_PUMPTEST:
                rbyte = {state.pump_test, 5'h00};
            RFTX_IDX_COMPDITH:
                rbyte = {state.comp_dith, 6'h00};
            RFTX_IDX_STATUS:
                // comparator sample is one when set current exceeds core
                rbyte = {1'b0, state.comp_sample, state.osc_current};
            default:
                rbyte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    assign sleep_gate = (sleep_mode_select == RFTX_SLEEP_MODE_GATED);
    // software toggles the override bit as a slow calibration clock
    assign cal_fall = state.osc_cal[RFTX_POS_MANUAL] && state.cal_clk_prev
        && !state.osc_cal[RFTX_POS_CUR_OVR];

    always_comb
    begin
        next_state = state;
        if (setup)
        begin
            next_state.rdata = {24'h000000, (aligned ? rbyte : 8'h00)};
        end
        if (wr)
        begin
            unique case (index)
                RFTX_IDX_POWER:
                    next_state.power = wbyte;
                RFTX_IDX_SLEEP:
                    next_state.sleep_bits = wbyte[7:4];
                RFTX_IDX_DACPUMP:
                    next_state.dac_pump = wbyte;
                RFTX_IDX_LOOP:
                    next_state.loop_ctl = wbyte;
                RFTX_IDX_OSCCAL:
                    next_state.osc_cal = wbyte;
                RFTX_IDX_PUMPTEST:
                    next_state.pump_test = wbyte[7:5];
                RFTX_IDX_COMPDITH:
                    next_state.comp_dith = wbyte[7:6];
                default:
                    next_state.power = state.power;
            endcase
        end
        next_state.cal_clk_prev = state.osc_cal[RFTX_POS_CUR_OVR];
        if (cal_fall)
        begin
            next_state.comp_sample = osc_cal_comp;
        end
        // sleep bits only bite in the gated sleep mode
        next_state.sleep_out = sleep_gate ? state.sleep_bits : 4'h0;
        next_state.loop_open = state.loop_ctl[RFTX_POS_BREAK];
        next_state.dac_drive = state.loop_ctl[RFTX_POS_BREAK]
            ? state.dac_pump[RFTX_POS_DAC_OPEN +: 4] : cal_dac_value;
        next_state.pump_current = state.loop_ctl[RFTX_POS_PUMP_OVR]
            ? state.dac_pump[RFTX_POS_PUMP_CO +: 4] : cal_pump_current;
        next_state.osc_array = state.loop_ctl[RFTX_POS_ARRAY_OVR]
            ? state.loop_ctl[RFTX_POS_ARRAY_AO +: 5] : cal_osc_array;
        next_state.osc_current = state.osc_cal[RFTX_POS_CUR_OVR]
            ? state.osc_cal[RFTX_POS_CUR_CO +: 6] : cal_osc_current;
        next_state.osc_cal_clk = state.osc_cal[RFTX_POS_MANUAL]
            && state.osc_cal[RFTX_POS_CUR_OVR];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= '0;
            state.power <= {RFTX_RST_HIGH, RFTX_RST_LOW};
            state.sleep_bits <= RFTX_RST_SLEEP;
            state.dac_pump <= {RFTX_RST_DAC_OPEN, RFTX_RST_PUMP_CO};
            state.loop_ctl <= {3'h0, RFTX_RST_ARRAY_AO};
            state.osc_cal <= {2'h0, RFTX_RST_CUR_CO};
            state.comp_dith <= {1'b0, RFTX_RST_DITHER};
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign high_array_level = state.power[RFTX_POS_HIGH +: 4];
    assign low_array_level = state.power[RFTX_POS_LOW +: 4];
    assign amp_sleep = state.sleep_out[RFTX_POS_AMP_SLEEP - 4];
    assign osc_sleep = state.sleep_out[RFTX_POS_OSC_SLEEP - 4];
    assign divider_buffer_sleep = state.sleep_out[RFTX_POS_DIV_SLEEP - 4];
    assign pump_sleep = state.sleep_out[RFTX_POS_PUMP_SLEEP - 4];
    assign loop_open = state.loop_open;
    assign dac_drive = state.dac_drive;
    assign pump_current = state.pump_current;
    assign osc_array = state.osc_array;
    assign osc_current = state.osc_current;
    assign osc_cal_clk = state.osc_cal_clk;
    assign pump_disable = state.pump_test[RFTX_POS_PUMP_DIS - 5];
    assign pump_force_up = state.pump_test[RFTX_POS_PUMP_UP - 5];
    assign pump_force_down = state.pump_test[RFTX_POS_PUMP_DN - 5];
    assign fcomp_out_en = state.comp_dith[RFTX_POS_FCOMP_EN - 6];
    assign modulator_dither_en = state.comp_dith[RFTX_POS_DITHER - 6];

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_power_write_lands:
    assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pstrb[0] && paddr == {RFTX_IDX_POWER, 2'h0})
        |=> high_array_level == $past(pwdata[7:4]) && low_array_level == $past(pwdata[3:0]))
    else $error("power write not applied");

    a_amp_sleep_gate:
    assert property (@(posedge pclk) disable iff (!presetn)
        amp_sleep |-> $past(sleep_mode_select) == RFTX_SLEEP_MODE_GATED
            && $past(state.sleep_bits[3]))
    else $error("amplifier sleep without gated mode");

    a_osc_sleep_follow:
    assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_mode_select == RFTX_SLEEP_MODE_GATED && state.sleep_bits[2]
            && !wr) |=> osc_sleep)
    else $error("oscillator sleep not applied");

    a_pump_sleep_off:
    assert property (@(posedge pclk) disable iff (!presetn)
        sleep_mode_select != RFTX_SLEEP_MODE_GATED |=> !pump_sleep && !divider_buffer_sleep)
    else $error("pump sleep outside gated mode");

    a_dac_override:
    assert property (@(posedge pclk) disable iff (!presetn)
        loop_open |-> dac_drive == $past(state.dac_pump[7:4]))
    else $error("open loop dac not from override");

    a_pump_override:
    assert property (@(posedge pclk) disable iff (!presetn)
        $past(state.loop_ctl[RFTX_POS_PUMP_OVR]) |-> pump_current == $past(state.dac_pump[3:0]))
    else $error("pump override not applied");

    a_array_select:
    assert property (@(posedge pclk) disable iff (!presetn)
        !state.loop_ctl[RFTX_POS_ARRAY_OVR] |=> osc_array == $past(cal_osc_array))
    else $error("array not from calibration");

    a_cal_sample:
    assert property (@(posedge pclk) disable iff (!presetn)
        (state.osc_cal[RFTX_POS_MANUAL] && $fell(state.osc_cal[RFTX_POS_CUR_OVR]))
        |=> state.comp_sample == $past(osc_cal_comp))
    else $error("comparator not sampled on falling clock");

    a_reserved_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == {RFTX_IDX_PUMPTEST, 2'h0}) |=> prdata[4:0] == 5'h00)
    else $error("reserved bits not zero");

    a_low_level_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && index == RFTX_IDX_POWER) |=> $stable(low_array_level))
    else $error("low array level changed without write");

    a_div_sleep_gate:
    assert property (@(posedge pclk) disable iff (!presetn)
        divider_buffer_sleep |-> $past(sleep_mode_select) == RFTX_SLEEP_MODE_GATED
            && $past(state.sleep_bits[1]))
    else $error("divider sleep without gated mode");

    a_dac_closed:
    assert property (@(posedge pclk) disable iff (!presetn)
        !state.loop_ctl[RFTX_POS_BREAK] |=> !loop_open && dac_drive == $past(cal_dac_value))
    else $error("closed loop dac not from calibration");

    a_pump_calibrated:
    assert property (@(posedge pclk) disable iff (!presetn)
        !state.loop_ctl[RFTX_POS_PUMP_OVR] |=> pump_current == $past(cal_pump_current))
    else $error("pump current not from calibration");

    a_array_override:
    assert property (@(posedge pclk) disable iff (!presetn)
        state.loop_ctl[RFTX_POS_ARRAY_OVR] |=> osc_array == $past(state.loop_ctl[4:0]))
    else $error("array override not applied");

    a_current_override:
    assert property (@(posedge pclk) disable iff (!presetn)
        state.osc_cal[RFTX_POS_CUR_OVR] |=> osc_current == $past(state.osc_cal[5:0]))
    else $error("current override not applied");

    a_cal_clock_follow:
    assert property (@(posedge pclk) disable iff (!presetn)
        osc_cal_clk |-> $past(state.osc_cal[7:6]) == 2'h3)
    else $error("calibration clock outside manual mode");

    a_pump_disable_bit:
    assert property (@(posedge pclk) disable iff (!presetn)
        (wr && index == RFTX_IDX_PUMPTEST) |=> pump_disable == $past(wbyte[RFTX_POS_PUMP_DIS]))
    else $error("pump disable bit not applied");

    a_pump_force_bits:
    assert property (@(posedge pclk) disable iff (!presetn)
        (wr && index == RFTX_IDX_PUMPTEST)
        |=> {pump_force_up, pump_force_down} == $past(wbyte[6:5]))
    else $error("pump force bits not applied");

    a_fcomp_enable:
    assert property (@(posedge pclk) disable iff (!presetn)
        (wr && index == RFTX_IDX_COMPDITH) |=> fcomp_out_en == $past(wbyte[RFTX_POS_FCOMP_EN]))
    else $error("comparator output enable not applied");

    a_dither_enable:
    assert property (@(posedge pclk) disable iff (!presetn)
        (wr && index == RFTX_IDX_COMPDITH)
        |=> modulator_dither_en == $past(wbyte[RFTX_POS_DITHER]))
    else $error("dither enable not applied");

    a_status_compare:
    assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == {RFTX_IDX_STATUS, 2'h0}) |=> prdata[6] == $past(state.comp_sample))
    else $error("status comparator bit not read back");

endmodule

// File: tb/rftx_host.sv
// rftx_host: apb master standing in for the host controller.
// assumes: one register per aligned word, pready sampled at rising pclk.
module rftx_host
(
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one transfer; the master waits as long as the slave takes
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
        input logic [3:0] strb, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show no stale value
        paddr <= ~{idx, 2'b00};
        pwdata <= ~{24'h000000, d};
    endtask
endmodule

// File: tb/test_rf_tx_pa_pll_test_regs.sv
// test_rf_tx_pa_pll_test_regs: self-checking bench for the register bank.
// assumes: host model drives apb; bench drives mode and calibrated inputs.
module test_rf_tx_pa_pll_test_regs
    import rftx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_cal_comp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, cal_dac_value, cal_pump_current, high_array_level, low_array_level;
    logic [3:0] dac_drive, pump_current;
    logic [1:0] sleep_mode_select;
    logic [4:0] cal_osc_array, osc_array;
    logic [5:0] cal_osc_current, osc_current;
    logic amp_sleep, osc_sleep, divider_buffer_sleep, pump_sleep, loop_open, osc_cal_clk;
    logic pump_disable, pump_force_up, pump_force_down, fcomp_out_en, modulator_dither_en;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    rftx_regs #(.ADDR_W(12)) rftx_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_mode_select(sleep_mode_select), .cal_dac_value(cal_dac_value),
        .cal_pump_current(cal_pump_current), .cal_osc_array(cal_osc_array),
        .cal_osc_current(cal_osc_current), .osc_cal_comp(osc_cal_comp),
        .high_array_level(high_array_level), .low_array_level(low_array_level),
        .amp_sleep(amp_sleep), .osc_sleep(osc_sleep),
        .divider_buffer_sleep(divider_buffer_sleep), .pump_sleep(pump_sleep),
        .loop_open(loop_open), .dac_drive(dac_drive), .pump_current(pump_current),
        .osc_array(osc_array), .osc_current(osc_current), .osc_cal_clk(osc_cal_clk),
        .pump_disable(pump_disable), .pump_force_up(pump_force_up),
        .pump_force_down(pump_force_down), .fcomp_out_en(fcomp_out_en),
        .modulator_dither_en(modulator_dither_en));

    rftx_host rftx_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            $display("unexpected at %0t: run did not end", $time);
            finish_test();
        end
    end

    // muxed and mode-gated outputs lag the register by one edge
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        rftx_host_i.xfer(1'b1, idx, d, 4'h1, q, e);
        check({31'h0, e}, 32'h0);
        // step off the access edge so direct outputs have taken the write
        #1;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        logic e;
        rftx_host_i.xfer(1'b0, idx, 8'h00, 4'h0, q, e);
        check(q, {24'h0, exp});
        check({31'h0, e}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [9:0] idx[7] = '{RFTX_IDX_POWER, RFTX_IDX_SLEEP, RFTX_IDX_DACPUMP,
            RFTX_IDX_LOOP, RFTX_IDX_OSCCAL, RFTX_IDX_PUMPTEST, RFTX_IDX_COMPDITH};
        logic [7:0] rv[7] = '{8'h0F, 8'h00, 8'h4D, 8'h10, 8'h06, 8'h00, 8'h40};
        settle();
        check({24'h0, high_array_level, low_array_level}, 32'h0F);
        check({18'h0, loop_open, dac_drive, pump_current, osc_array}, 32'h00000647);
        check({26'h0, osc_current}, 32'h21);
        check({22'h0, amp_sleep, osc_sleep, divider_buffer_sleep, pump_sleep, osc_cal_clk,
            pump_disable, pump_force_up, pump_force_down, fcomp_out_en,
            modulator_dither_en}, 32'h1);
        foreach (idx[i])
            rd(idx[i], rv[i]);
    endtask

    // low nibble alone first, then both nibbles at once to F and 0
    task automatic t_power();
        wr(RFTX_IDX_POWER, 8'h0A);
        check({24'h0, high_array_level, low_array_level}, 32'h0A);
        wr(RFTX_IDX_POWER, 8'hF0);
        check({24'h0, high_array_level, low_array_level}, 32'hF0);
    endtask

    task automatic t_sleep();
        logic [7:0] pat[2] = '{8'hAF, 8'h5F};
        foreach (pat[p])
        begin
            wr(RFTX_IDX_SLEEP, pat[p]);
            rd(RFTX_IDX_SLEEP, {pat[p][7:4], 4'h0});
            for (int m = 0; m < 4; m++)
            begin
                @(posedge pclk);
                sleep_mode_select <= m[1:0];
                settle();
                check({28'h0, amp_sleep, osc_sleep, divider_buffer_sleep, pump_sleep},
                    (m == 2) ? {28'h0, pat[p][7:4]} : 32'h0);
            end
        end
        @(posedge pclk);
        sleep_mode_select <= 2'h0;
    endtask

    task automatic t_override();
        wr(RFTX_IDX_DACPUMP, 8'h9C);
        wr(RFTX_IDX_LOOP, 8'hFB);
        settle();
        check({18'h0, loop_open, dac_drive, pump_current, osc_array}, 32'h0000339B);
        wr(RFTX_IDX_LOOP, 8'h1B);
        settle();
        check({18'h0, loop_open, dac_drive, pump_current, osc_array}, 32'h00000647);
        wr(RFTX_IDX_OSCCAL, 8'h6A);
        settle();
        check({25'h0, osc_cal_clk, osc_current}, 32'h2A);
        wr(RFTX_IDX_OSCCAL, 8'h2A);
        settle();
        check({25'h0, osc_cal_clk, osc_current}, 32'h21);
    endtask

    task automatic t_test_bits();
        wr(RFTX_IDX_PUMPTEST, 8'hFF);
        rd(RFTX_IDX_PUMPTEST, 8'hE0);
        check({29'h0, pump_disable, pump_force_up, pump_force_down}, 32'h7);
        wr(RFTX_IDX_PUMPTEST, 8'h20);
        check({29'h0, pump_disable, pump_force_up, pump_force_down}, 32'h1);
        wr(RFTX_IDX_COMPDITH, 8'hFF);
        rd(RFTX_IDX_COMPDITH, 8'hC0);
        wr(RFTX_IDX_COMPDITH, 8'h80);
        check({30'h0, fcomp_out_en, modulator_dither_en}, 32'h2);
    endtask

    // comparator level flips around the falling write to prove the sample edge
    task automatic t_manual();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge pclk);
            osc_cal_comp <= ~v[0];
            wr(RFTX_IDX_OSCCAL, 8'hC0);
            settle();
            check({31'h0, osc_cal_clk}, 32'h1);
            @(posedge pclk);
            osc_cal_comp <= v[0];
            wr(RFTX_IDX_OSCCAL, 8'h80);
            settle();
            @(posedge pclk);
            osc_cal_comp <= ~v[0];
            rd(RFTX_IDX_STATUS, {1'b0, v[0], 6'h21});
        end
    endtask

    task automatic t_refuse();
        logic [31:0] q;
        logic e;
        rftx_host_i.xfer(1'b1, 10'h030, 8'h55, 4'h1, q, e);
        check({31'h0, e}, 32'h1);
        rftx_host_i.xfer(1'b0, 10'h030, 8'h00, 4'h0, q, e);
        check({q[30:0], e}, 32'h1);
        rftx_host_i.xfer(1'b1, RFTX_IDX_POWER, 8'h33, 4'h0, q, e);
        rd(RFTX_IDX_POWER, 8'hF0);
        wr(RFTX_IDX_STATUS, 8'hFF);
        rd(RFTX_IDX_STATUS, 8'h21);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        sleep_mode_select = 2'h0;
        cal_dac_value = 4'h3;
        cal_pump_current = 4'h2;
        cal_osc_array = 5'h07;
        cal_osc_current = 6'h21;
        osc_cal_comp = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_power();
        t_sleep();
        t_override();
        t_test_bits();
        t_manual();
        t_refuse();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        finish_test();
    end
endmodule
